// File: bench/buck_cfg_sva.sv
// Port checks for the buck configuration bank
`timescale 1ns/1ps
`default_nettype none
module buck_cfg_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic hard_reset,
  input wire logic regulator_enable,
  input wire logic multipurpose_pin_two,
  input wire logic integrator_disable,
  input wire logic power_good_transition_enable,
  input wire logic passive_discharge,
  input wire logic active_discharge,
  input wire logic fast_mode_request,
  input wire logic adaptive_peak_disable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  integ_follow_a: assert property (wr_en && addr == 8'h31 |->
    ##2 integrator_disable == $past(wdata[7], 2)) else $error("integ");
  power_good_comparator_follow_a: assert property (wr_en && addr == 8'h31 |->
    ##2 power_good_transition_enable == $past(wdata[6], 2)) else $error("pg");
  adapt_follow_a: assert property (wr_en && addr == 8'h32 |->
    ##2 adaptive_peak_disable == $past(wdata[3], 2)) else $error("adapt");
  // Register reset loads constants, so a hard reset seen under rst is exempt
  hard_dsc_a: assert property (!rst && hard_reset |=>
    passive_discharge && active_discharge) else $error("hard dsc");
  act_idle_a: assert property (!hard_reset && regulator_enable |=>
    !active_discharge) else $error("act dsc");
  pin_gate_a: assert property (!multipurpose_pin_two |=>
    !fast_mode_request) else $error("pin gate");
  rd_idle_a: assert property (!rd_en |=> rdata == 8'h00)
    else $error("rd idle");
  sec_low_a: assert property (rd_en && addr == 8'h32 |=>
    rdata[2:0] == 3'h0) else $error("sec low");
  unmapped_rd_a: assert property (rd_en && addr != 8'h31 &&
    addr != 8'h32 |=> rdata == 8'h00) else $error("unmapped");
endmodule // buck_cfg_chk
bind buck_regulator_config_regs buck_cfg_chk chk_i (.*);
`default_nettype wire

// File: bench/tb_top.sv
// Register and control-line tests for the buck configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hard_reset = 1'b0;
  logic regulator_enable = 1'b1;
  logic multipurpose_pin_two = 1'b0;
  wire [7:0] rdata;
  wire [12:0] obs;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] p = 8'h50;
  logic [7:0] s = 8'h00;
  logic [7:0] pat [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
  buck_regulator_config_regs uut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .hard_reset(hard_reset),
    .regulator_enable(regulator_enable),
    .multipurpose_pin_two(multipurpose_pin_two),
    .integrator_disable(obs[12]), .power_good_transition_enable(obs[11]),
    .pretrigger_fast_mode(obs[10]), .passive_discharge(obs[9]),
    .active_discharge(obs[8]), .slow_edge_mode(obs[7]), .fet_halving(obs[6]),
    .switch_node_sense_select(obs[5]), .reduced_bandwidth_mode(obs[4]),
    .forced_discontinuous_mode(obs[3]), .fast_mode_request(obs[2]),
    .forced_pwm_mode(obs[1]), .adaptive_peak_disable(obs[0]));
  always #2.5 core_clk = ~core_clk;
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [12:0] e,
    input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk("rdata", {5'h00, e}, {5'h00, rdata});
  endtask
  // Controls lag pin inputs by one cycle and register writes by two
  task automatic ctl;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("ctl", {p[7:5], hard_reset | p[4] & ~regulator_enable,
      hard_reset | p[3] & ~regulator_enable, p[2:0], s[7:6],
      s[5] & multipurpose_pin_two, s[4:3]}, obs);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h31, 8'h50);
    rd(8'h32, 8'h00);
    ctl();
    for (int i = 0; i < 4; i++) begin
      p = pat[i];
      s = pat[i] & 8'hf8;
      wr(8'h31, pat[i]);
      wr(8'h32, pat[i]);
      rd(8'h31, p);
      rd(8'h32, s);
      for (int j = 0; j < 8; j++) begin
        @(posedge core_clk);
        {hard_reset, regulator_enable, multipurpose_pin_two} <= j[2:0];
        ctl();
      end
    end
    // Unmapped offset must read zero and not alias onto the primary register
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h00);
    rd(8'h31, p);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    p = 8'h50;
    s = 8'h00;
    rd(8'h31, 8'h50);
    rd(8'h32, 8'h00);
    ctl();
    end_sim;
  end
endmodule // tb_top
`default_nettype wire

// File: pkg/buck_cfg_consts.svh
// Offsets, field positions and reset values of the buck configuration bank
`ifndef BUCK_CFG_CONSTS_SVH
`define BUCK_CFG_CONSTS_SVH
`define ADDR_W 8
`define OFS_PRIMARY 8'h31
`define OFS_SECONDARY 8'h32
`define RST_PRIMARY 8'h50
`define RST_SECONDARY 8'h00
`define SEC_MASK 8'hf8
`define P_INTEGRATOR_DISABLE 7
`define P_POWER_GOOD_TRANSITION_ENABLE 6
`define P_PRETRIGGER_FAST_MODE 5
`define P_PASSIVE_DISCHARGE_ON_DISABLE 4
`define P_ACTIVE_DISCHARGE_ON_DISABLE 3
`define P_SLOW_EDGE_MODE 2
`define P_FET_HALVING 1
`define P_SWITCH_NODE_SENSE_SELECT 0
`define S_REDUCED_BANDWIDTH_MODE 7
`define S_FORCED_DISCONTINUOUS_MODE 6
`define S_PIN_CONTROLLED_FAST_MODE 5
`define S_FORCED_PWM_MODE 4
`define S_ADAPTIVE_PEAK_DISABLE 3
`endif

// File: pkg/buck_cfg_pkg.sv
// Types shared by the buck configuration bank
package buck_cfg_pkg;
  typedef enum logic [2:0] {
    sel_none = 3'b001,
    sel_primary = 3'b010,
    sel_secondary = 3'b100
  } reg_sel_t;
endpackage

// File: pkg/cfg_store_if.sv
// Write and read path between decoder and register store
`timescale 1ns/1ps
`default_nettype none
interface cfg_store_if;
  logic wr_primary;
  logic wr_secondary;
  logic [7:0] wdata;
  logic [7:0] primary;
  logic [7:0] secondary;
  modport ctrl (output wr_primary, output wr_secondary, output wdata,
    input primary, input secondary);
  modport store (input wr_primary, input wr_secondary, input wdata,
    output primary, output secondary);
endinterface
`default_nettype wire

// File: verilog/buck_cfg_store.sv
// Two configuration registers with their reset defaults
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg_consts.svh"
module buck_cfg_store (
  input wire logic core_clk,
  input wire logic rst,
  cfg_store_if.store bus
);
  logic [7:0] primary;
  logic [7:0] secondary;
  logic [7:0] next_primary;
  logic [7:0] next_secondary;

  always_comb begin
    next_primary = primary;
    next_secondary = secondary;
    if (bus.wr_primary) begin
      next_primary = bus.wdata;
    end
    if (bus.wr_secondary) begin
      next_secondary = bus.wdata & `SEC_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primary <= `RST_PRIMARY;
      secondary <= `RST_SECONDARY;
    end else begin
      primary <= next_primary;
      secondary <= next_secondary;
    end
  end

  assign bus.primary = primary;
  assign bus.secondary = secondary;
endmodule // buck_cfg_store
`default_nettype wire

// File: verilog/buck_regulator_config_regs.sv
// Buck configuration registers and decoded analog control lines
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg_consts.svh"
// Function
// - Primary bit 7 set disables integrator, leaving proportional control
// - Primary bit 6 enables power-good comparator in transitions, reset 1
// - Primary bit 5 selects high-quiescent pretrigger fast mode
// - Passive discharge in hard reset; also when enable low if bit 4
// - Active discharge in hard reset; also when enable low if bit 3
// - Primary bit 2 slows switch-node edges threefold
// - Primary bit 1 halves effective power FET size
// - Primary bit 0 selects freewheeling entry on switch-node high
// - Secondary bit 7 selects low loop bandwidth
// - Secondary bit 6 forces discontinuous conduction
// - Secondary bit 5 lets pin two level steer fast mode
// - Secondary bit 4 forces PWM switching
// - Secondary bit 3 fixes peak current instead of adaptive
module buck_regulator_config_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic hard_reset,
  input wire logic regulator_enable,
  input wire logic multipurpose_pin_two,
  output logic integrator_disable,
  output logic power_good_transition_enable,
  output logic pretrigger_fast_mode,
  output logic passive_discharge,
  output logic active_discharge,
  output logic slow_edge_mode,
  output logic fet_halving,
  output logic switch_node_sense_select,
  output logic reduced_bandwidth_mode,
  output logic forced_discontinuous_mode,
  output logic fast_mode_request,
  output logic forced_pwm_mode,
  output logic adaptive_peak_disable
);
  cfg_store_if store_bus ();
  buck_cfg_pkg::reg_sel_t sel;
  logic [7:0] p;
  logic [7:0] s;
  logic [7:0] next_rdata;
  logic [12:0] ctl;
  logic [12:0] next_ctl;

  function automatic buck_cfg_pkg::reg_sel_t decode(input logic [7:0] a);
    if (a == `OFS_PRIMARY) begin
      decode = buck_cfg_pkg::sel_primary;
    end else if (a == `OFS_SECONDARY) begin
      decode = buck_cfg_pkg::sel_secondary;
    end else begin
      decode = buck_cfg_pkg::sel_none;
    end
  endfunction

  assign sel = decode(addr);
  assign store_bus.wdata = wdata;
  assign store_bus.wr_primary = wr_en && (sel == buck_cfg_pkg::sel_primary);
  assign store_bus.wr_secondary =
    wr_en && (sel == buck_cfg_pkg::sel_secondary);
  assign p = store_bus.primary;
  assign s = store_bus.secondary;

  buck_cfg_store u_store (
    .core_clk(core_clk),
    .rst(rst),
    .bus(store_bus.store)
  );

  // Unmapped reads return zero; data stands one cycle only
  always_comb begin
    next_rdata = 8'h00;
    if (rd_en) begin
      case (sel)
        buck_cfg_pkg::sel_primary: begin
          next_rdata = p;
        end
        buck_cfg_pkg::sel_secondary: begin
          next_rdata = s;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    next_ctl[0] = p[`P_INTEGRATOR_DISABLE];
    next_ctl[1] = p[`P_POWER_GOOD_TRANSITION_ENABLE];
    next_ctl[2] = p[`P_PRETRIGGER_FAST_MODE];
    next_ctl[3] = hard_reset ||
      (p[`P_PASSIVE_DISCHARGE_ON_DISABLE] && !regulator_enable);
    next_ctl[4] = hard_reset ||
      (p[`P_ACTIVE_DISCHARGE_ON_DISABLE] && !regulator_enable);
    next_ctl[5] = p[`P_SLOW_EDGE_MODE];
    next_ctl[6] = p[`P_FET_HALVING];
    next_ctl[7] = p[`P_SWITCH_NODE_SENSE_SELECT];
    next_ctl[8] = s[`S_REDUCED_BANDWIDTH_MODE];
    next_ctl[9] = s[`S_FORCED_DISCONTINUOUS_MODE];
    next_ctl[10] = s[`S_PIN_CONTROLLED_FAST_MODE] && multipurpose_pin_two;
    next_ctl[11] = s[`S_FORCED_PWM_MODE];
    next_ctl[12] = s[`S_ADAPTIVE_PEAK_DISABLE];
  end

  // Registered outputs; reset value mirrors register defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      ctl <= 13'h000a;
    end else begin
      rdata <= next_rdata;
      ctl <= next_ctl;
    end
  end

  assign integrator_disable = ctl[0];
  assign power_good_transition_enable = ctl[1];
  assign pretrigger_fast_mode = ctl[2];
  assign passive_discharge = ctl[3];
  assign active_discharge = ctl[4];
  assign slow_edge_mode = ctl[5];
  assign fet_halving = ctl[6];
  assign switch_node_sense_select = ctl[7];
  assign reduced_bandwidth_mode = ctl[8];
  assign forced_discontinuous_mode = ctl[9];
  assign fast_mode_request = ctl[10];
  assign forced_pwm_mode = ctl[11];
  assign adaptive_peak_disable = ctl[12];
endmodule // buck_regulator_config_regs
`default_nettype wire
